// [aox_defs.svh]
// constants for the accumulator or/xor logic unit
`ifndef AOX_DEFS_SVH
`define AOX_DEFS_SVH
`define AOX_ACC_W      32
`define AOX_WORD_W     16
`define AOX_STACK_D    8
`define AOX_CNT_W      6
`define AOX_CNT_MIN    6'h01
`define AOX_CNT_MAX    6'h20
`define AOX_ACC_RST    32'h0000_0000
`endif

// [aox_pkg.sv]
// types for the accumulator or/xor logic unit
package aox_pkg;
    typedef enum logic [2:0] {
        AOX_OR_WORD,
        AOX_OR_DOUBLE_OP,
        AOX_OR_FORMATTED_OP,
        AOX_OR_STACK_OP,
        AOX_XOR_WORD,
        AOX_XOR_DOUBLE_OP
    } aox_op_e;

    // instruction request from the sequencer
    typedef struct packed {
        logic        valid;
        aox_op_e     op;
        logic [31:0] operand;
        logic [5:0]  bit_count;
    } aox_req_s;

    typedef struct packed {
        logic zero_result_flag;
        logic negative_result_flag;
    } aox_flags_s;
endpackage : aox_pkg

// [aox_unit.sv]
// accumulator or/xor logic unit with accumulator stack
`timescale 1ns/10ps
`include "aox_defs.svh"

// Operation
// - word OR merges low half into accumulator
// - word OR sets zero flag on zero
// - flags hold only latest updating instruction
// - double OR with 32-bit memory/constant operand
// - double OR sets zero and negative flags
// - negative flag follows result sign bit
// - 32-bit forms: zero flag on zero result
// - formatted OR merges 1 to 32 bits
// - formatted OR sets zero, negative flags
// - stack OR with top entry, flags updated
// - stack pop moves entries up one level
// - word XOR with low half, zero flag
// - word XOR signals zero result
// - double XOR with constant, both flags
module aox_unit
    import aox_pkg::*;
#(
    parameter int STACK_DEPTH = `AOX_STACK_D
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_arst_n,
    // instruction request
    input  wire aox_req_s              i_req,
    // stack push from sequencer
    input  wire logic                  i_push,
    input  wire logic [`AOX_ACC_W-1:0] i_push_data,
    // results
    output logic [`AOX_ACC_W-1:0]      o_acc,
    output logic [`AOX_ACC_W-1:0]      o_stack_top,
    output aox_flags_s                 o_flags,
    output logic                       o_done
);

    typedef struct packed {
        logic [`AOX_ACC_W-1:0]                  acc;
        logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] stack;
        aox_flags_s                             flags;
        logic                                   done;
    } aox_state_s;

    aox_state_s state;
    aox_state_s next_state;

    // keep only the low count bits of a discrete run
    function automatic logic [`AOX_ACC_W-1:0] run_mask(input logic [5:0] cnt);
        logic [`AOX_ACC_W-1:0] m;
        m = '0;
        for (int k = 0; k < `AOX_ACC_W; k++) begin
            if (6'(k) < cnt) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction : run_mask

    // legal instruction codes; the two spare codes are ignored
    function automatic logic is_legal_op(input aox_op_e op);
        logic legal;
        legal = 1'b0;
        unique case (op)
            AOX_OR_WORD,
            AOX_OR_DOUBLE_OP,
            AOX_OR_FORMATTED_OP,
            AOX_OR_STACK_OP,
            AOX_XOR_WORD,
            AOX_XOR_DOUBLE_OP: begin
                legal = 1'b1;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
        return legal;
    endfunction : is_legal_op

    // word forms touch only the low half; the high half is carried through
    function automatic logic [`AOX_ACC_W-1:0] word_merge(
        input logic [`AOX_ACC_W-1:0]  acc,
        input logic [`AOX_WORD_W-1:0] word,
        input logic                   use_xor
    );
        logic [`AOX_WORD_W-1:0] low;
        low = use_xor ? (acc[`AOX_WORD_W-1:0] ^ word) : (acc[`AOX_WORD_W-1:0] | word);
        return {acc[`AOX_ACC_W-1:`AOX_WORD_W], low};
    endfunction : word_merge

    // both flags are rebuilt from the full accumulator result
    function automatic aox_flags_s flags_of(input logic [`AOX_ACC_W-1:0] res);
        aox_flags_s f;
        f.zero_result_flag = (res == '0);
        f.negative_result_flag = res[`AOX_ACC_W-1];
        return f;
    endfunction : flags_of

    // top entry leaves, the rest move up one level
    function automatic logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] pop_stack(
        input logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] stk
    );
        logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] nxt;
        nxt = stk;
        for (int k = 0; k < STACK_DEPTH - 1; k++) begin
            nxt[k] = stk[k+1];
        end
        nxt[STACK_DEPTH-1] = '0;
        return nxt;
    endfunction : pop_stack

    // new value enters at the top, the deepest entry falls off
    function automatic logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] push_stack(
        input logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] stk,
        input logic [`AOX_ACC_W-1:0]                  val
    );
        logic [STACK_DEPTH-1:0][`AOX_ACC_W-1:0] nxt;
        nxt = stk;
        for (int k = STACK_DEPTH - 1; k > 0; k--) begin
            nxt[k] = stk[k-1];
        end
        nxt[0] = val;
        return nxt;
    endfunction : push_stack

    always_comb begin
        logic [`AOX_ACC_W-1:0] res;
        logic                  upd;
        logic                  pop;
        res = state.acc;
        upd = 1'b0;
        pop = 1'b0;
        next_state = state;
        next_state.done = 1'b0;
        if (i_req.valid) begin
            upd = is_legal_op(i_req.op);
            unique case (i_req.op)
                AOX_OR_WORD: begin
                    res = word_merge(state.acc, i_req.operand[`AOX_WORD_W-1:0], 1'b0);
                end
                AOX_OR_DOUBLE_OP: begin
                    res = state.acc | i_req.operand;
                end
                AOX_OR_FORMATTED_OP: begin
                    res = state.acc | (i_req.operand & run_mask(i_req.bit_count));
                end
                AOX_OR_STACK_OP: begin
                    res = state.acc | state.stack[0];
                    pop = 1'b1;
                end
                AOX_XOR_WORD: begin
                    res = word_merge(state.acc, i_req.operand[`AOX_WORD_W-1:0], 1'b1);
                end
                AOX_XOR_DOUBLE_OP: begin
                    res = state.acc ^ i_req.operand;
                end
                default: begin
                    res = state.acc;
                end
            endcase
        end
        if (upd) begin
            next_state.acc  = res;
            next_state.done = 1'b1;
            next_state.flags = flags_of(res);
        end
        // a stack or consumes its operand, so it wins over a push
        if (pop) begin
            next_state.stack = pop_stack(state.stack);
        end else if (i_push) begin
            next_state.stack = push_stack(state.stack, i_push_data);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        o_acc       = state.acc;
        o_stack_top = state.stack[0];
        o_flags     = state.flags;
        o_done      = state.done;
    end

endmodule : aox_unit

// [aox_unit_asserts.sv]
// port assertions for the or/xor unit
`timescale 1ns/10ps
module aox_unit_asserts
    import aox_pkg::*;
(
    // clock, reset, request and results
    input wire logic        i_ref_clk,
    input wire logic        i_arst_n,
    input wire aox_req_s    i_req,
    input wire logic [31:0] o_acc,
    input wire logic [31:0] o_stack_top,
    input wire aox_flags_s  o_flags,
    input wire logic        o_done
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    wire [2:0]  op = i_req.op;
    wire [31:0] k  = i_req.operand;
    wire        ok = i_req.valid && op < 6;
    wire [31:0] fm = (i_req.bit_count > 31) ? 32'hffff_ffff : ((32'h1 << i_req.bit_count) - 32'h1);
    a_done_follows: assert property (ok |=> o_done) else $error("no done");
    a_refused_op: assert property (!ok |=> !o_done && $stable(o_flags)) else $error("refused op acted");
    a_zero_flag: assert property (o_done |-> o_flags[1] == (o_acc == 0)) else $error("zero flag");
    a_neg_flag: assert property (o_done |-> o_flags[0] == o_acc[31]) else $error("neg flag");
    a_double_or: assert property (ok && op == 1 |=> o_acc == ($past(o_acc) | $past(k))) else $error("or");
    a_double_xor: assert property (ok && op == 5 |=> o_acc == ($past(o_acc) ^ $past(k))) else $error("xor");
    a_stack_or: assert property (ok && op == 3 |=> o_acc == ($past(o_acc) | $past(o_stack_top)))
        else $error("stack or");
    a_word_or: assert property (ok && op == 0 |=> o_acc == ($past(o_acc) | ($past(k) & 32'h0000_ffff)))
        else $error("word or");
    a_word_xor: assert property (ok && op == 4 |=> o_acc == ($past(o_acc) ^ ($past(k) & 32'h0000_ffff)))
        else $error("word xor");
    a_formatted_or: assert property (ok && op == 2 |=> o_acc == ($past(o_acc) | ($past(k) & $past(fm))))
        else $error("formatted or");
endmodule : aox_unit_asserts
bind aox_unit aox_unit_asserts chk (.i_ref_clk, .i_arst_n, .i_req, .o_acc, .o_stack_top, .o_flags, .o_done);

// [aox_seq.sv]
// sequencer stand-in issuing requests and pushes
`timescale 1ns/10ps
module aox_seq
    import aox_pkg::*;
(
    // request side
    output aox_req_s    o_req,
    output logic        o_push,
    output logic [31:0] o_push_data
);
    // drive one request together with the push flag and push value
    task go(input aox_req_s r, input logic p, input logic [31:0] v);
        o_req = r;
        o_push = p;
        o_push_data = v;
    endtask : go
endmodule : aox_seq

// [aox_unit_tb_top.sv]
// bench for the or/xor unit
`timescale 1ns/10ps
module aox_unit_tb_top
    import aox_pkg::*;
;
    logic        ck = 0, rst_n = 0, dn, pu;
    logic [31:0] pd, acc, top, ea, s[8];
    logic [1:0]  ef;
    aox_req_s    q;
    aox_flags_s  fl;
    int          errors = 0, checks = 0, cyc = 0;
    always #50 ck = ~ck;
    aox_seq seq (.o_req(q), .o_push(pu), .o_push_data(pd));
    aox_unit dut (.i_ref_clk(ck), .i_arst_n(rst_n), .i_req(q), .i_push(pu), .i_push_data(pd),
                  .o_acc(acc), .o_stack_top(top), .o_flags(fl), .o_done(dn));
    task give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task compare_result(input logic [66:0] got, input logic [66:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: %s mismatch", $time, what);
        end
    endtask : compare_result
    task step(input logic [2:0] o, input logic [31:0] d, input logic [5:0] c);
        logic        ok, p;
        logic [31:0] v;
        int          i;
        ok = o < 6;
        p = 1'($urandom);
        v = $urandom;
        seq.go('{1'b1, aox_op_e'(o), d, c}, p, v);
        case (o)
            0: ea[15:0] |= d[15:0];
            1: ea |= d;
            2: ea |= d & ((c > 31) ? '1 : (32'h1 << c) - 1);
            3: ea |= s[0];
            4: ea[15:0] ^= d[15:0];
            5: ea ^= d;
        endcase
        // pop wins over a push in the same cycle
        if (ok && o == 3) begin
            for (i = 0; i < 7; i++) begin
                s[i] = s[i+1];
            end
            s[7] = 32'h0;
        end else if (p) begin
            for (i = 7; i > 0; i--) begin
                s[i] = s[i-1];
            end
            s[0] = v;
        end
        if (ok) ef = {ea == 0, ea[31]};
        @(negedge ck);
        compare_result({acc, top, fl, dn}, {ea, s[0], ef, ok}, "result");
    endtask : step
    always @(posedge ck) begin
        cyc++;
        if (cyc > 1000) begin
            errors++;
            give_verdict;
        end
    end
    initial begin
        void'($urandom(32'h290d));
        {ea, ef} = '0;
        s = '{default: 0};
        seq.go('0, 0, 0);
        repeat (6) @(negedge ck);
        rst_n = 1;
        repeat (400) step(3'($urandom), $urandom, 6'(1 + $urandom % 32));
        $display("random mix done");
        step(5, ea, 1);
        step(2, 32'hffff_fffe, 1);
        step(2, '1, 32);
        repeat (9) step(3, 0, 1);
        $display("bounds and drain done");
        seq.go('0, 0, 0);
        rst_n = 0;
        @(negedge ck);
        compare_result({acc, top, fl, dn}, 67'h0, "reset");
        rst_n = 1;
        {ea, ef} = '0;
        s = '{default: 0};
        step(1, 32'h8000_0001, 1);
        step(4, 32'h0000_0001, 1);
        $display("mid-run reset done");
        give_verdict;
    end
endmodule : aox_unit_tb_top
